// [bus_requester.sv]
// Model of an outside device that asks for the external bus.
// Assumes the bench tells it when to want the bus, via want.
`timescale 1ns/1ps
module bus_requester (
  input wire logic aclk,
  input wire logic want,
  input wire logic bus_grant_n,
  output logic bus_request_n,
  output logic granted
);
  // ----------------------------------------------------------------
  // Request pin and grant observation
  // ----------------------------------------------------------------
  // Request pin is a plain level; no pull, so it is always driven
  always @(posedge aclk) begin
    bus_request_n <= ~want;
  end
  // Only counts as holding the bus while both pins are low
  assign granted = ~bus_request_n & ~bus_grant_n;
endmodule : bus_requester

// [ext_bus_config_register.sv]
// Configuration and status register of the external memory interface,
// with base timing tick generation and external bus grant control.
// Assumes bus_request_n arrives asynchronously from a pin.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

// Overview of operation
// (R1) Ratio field 18-16 selects undivided or halved clock
// (R2) Zone phases count base timing ticks
// (R3) One timing tick shared by every zone
// (R4) Software changes ratio only from outside memory
// (R5) Bit 11 reads the grant output level
// (R6) Bit 10 reads the request input level
// (R7) Bit 9 controls granting bus to requester
// (R8) Hold 0 grants automatically; 1 withholds grant
// (R9) Hold resets 0; setting revokes grant two cycles after the write
// (R10) Software writes only the two defined ratios
module ext_bus_config_register
  import ext_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_request_n,
  output logic bus_grant_n,
  output logic bus_release,
  output logic timing_tick,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cfg_s cfg_reg;
  logic req_meta_reg;
  logic req_sync_reg;
  logic req_prev_reg;
  logic grant_n_reg;
  logic release_reg;
  logic tick_reg;
  logic [EVENT_COUNT-1:0] status_reg;
  logic [EVENT_COUNT-1:0] mask_reg;
  logic irq_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic commit;
  logic aw_have_next;
  logic w_have_next;
  logic bvalid_next;
  logic rvalid_next;
  slot_e wr_slot;
  slot_e rd_slot;
  logic [EVENT_COUNT-1:0] events;
  logic [EVENT_COUNT-1:0] status_next;
  logic grant_n_next;
  logic tick_next;
  logic [31:0] cfg_view;

  function automatic slot_e decode(input logic [31:0] addr);
    slot_e s;
    s = SLOT_NONE;
    if (addr[31:4] == 28'h0 && addr[1:0] == 2'h0) begin
      case (addr[3:0])
        CFG_OFFSET: s = SLOT_CFG;
        IRQ_STATUS_OFFSET: s = SLOT_STATUS;
        IRQ_MASK_OFFSET: s = SLOT_MASK;
        default: s = SLOT_NONE;
      endcase
    end
    return s;
  endfunction : decode

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  assign aw_take = s_axi_awvalid && awready_reg;
  assign w_take = s_axi_wvalid && wready_reg;
  assign ar_take = s_axi_arvalid && arready_reg;
  assign commit = aw_have_reg && w_have_reg && !bvalid_reg;
  assign aw_have_next = (aw_have_reg || aw_take) && !commit;
  assign w_have_next = (w_have_reg || w_take) && !commit;
  assign bvalid_next = commit || (bvalid_reg && !s_axi_bready);
  assign rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
  assign wr_slot = decode(awaddr_reg);
  assign rd_slot = decode(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      // Hold off new work until the pending response is taken
      awready_reg <= !aw_have_next && !bvalid_next;
      wready_reg <= !w_have_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_reg <= RESP_OKAY;
    end else if (commit) begin
      bresp_reg <= (wr_slot == SLOT_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // Register view and read data
  // ----------------------------------------------------------------
  always_comb begin
    cfg_view = 32'h0;
    cfg_view[RATIO_MSB:RATIO_LSB] = cfg_reg.ratio;
    cfg_view[GRANT_STATE_BIT] = grant_n_reg; // R5
    cfg_view[REQUEST_STATE_BIT] = req_sync_reg; // R6
    cfg_view[HOLD_CTRL_BIT] = cfg_reg.hold;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      rresp_reg <= RESP_OKAY;
      case (rd_slot)
        SLOT_CFG: rdata_reg <= cfg_view;
        SLOT_STATUS: rdata_reg <= {29'h0, status_reg};
        SLOT_MASK: rdata_reg <= {29'h0, mask_reg};
        default: begin
          rdata_reg <= 32'h0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration writes
  // ----------------------------------------------------------------
  // Reserved ratios are stored as written; the divider treats them as
  // halved, the slower and safer of the two timings.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CFG_RESET; // R9
    end else if (commit && wr_slot == SLOT_CFG) begin
      if (wstrb_reg[2]) begin
        cfg_reg.ratio <= wdata_reg[RATIO_MSB:RATIO_LSB]; // R1
      end
      if (wstrb_reg[1]) begin
        cfg_reg.hold <= wdata_reg[HOLD_CTRL_BIT]; // R7
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= MASK_RESET;
    end else if (commit && wr_slot == SLOT_MASK && wstrb_reg[0]) begin
      mask_reg <= wdata_reg[EVENT_COUNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Base timing tick
  // ----------------------------------------------------------------
  // One tick for all zones; phase counters advance only on it
  assign tick_next = (cfg_reg.ratio == RATIO_DIV1) ? 1'b1 : !tick_reg; // R1 R3

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next; // R2
    end
  end

  // ----------------------------------------------------------------
  // Bus request and grant
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_meta_reg <= 1'b1;
      req_sync_reg <= 1'b1;
      req_prev_reg <= 1'b1;
    end else begin
      req_meta_reg <= bus_request_n;
      req_sync_reg <= req_meta_reg;
      req_prev_reg <= req_sync_reg;
    end
  end

  // Grant follows request unless hold is set
  assign grant_n_next = cfg_reg.hold ? 1'b1 : req_sync_reg; // R8

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_n_reg <= 1'b1;
      release_reg <= 1'b0;
    end else begin
      grant_n_reg <= grant_n_next; // R7 R9
      release_reg <= !grant_n_next;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign events[EV_REQUEST] = !req_sync_reg && req_prev_reg;
  assign events[EV_GRANT] = grant_n_reg && !grant_n_next;
  assign events[EV_RELEASE] = !grant_n_reg && grant_n_next;

  // A new event wins over the clear of a status read
  always_comb begin
    status_next = status_reg;
    if (ar_take && rd_slot == SLOT_STATUS) begin
      status_next = '0;
    end
    status_next = status_next | events;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign bus_grant_n = grant_n_reg;
  assign bus_release = release_reg;
  assign timing_tick = tick_reg;
  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_hold_write;
    commit && wr_slot == SLOT_CFG && wstrb_reg[1] && wdata_reg[HOLD_CTRL_BIT];
  endsequence

  sequence s_granted;
    !grant_n_reg && !req_sync_reg;
  endsequence

  a_ratio_undivided: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    cfg_reg.ratio == RATIO_DIV1 |=> tick_reg)
    else $error("tick missing at undivided ratio");
  a_tick_alternates: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    (cfg_reg.ratio == RATIO_DIV2) && $past(cfg_reg.ratio == RATIO_DIV2) |=> tick_reg != $past(tick_reg))
    else $error("halved tick does not alternate");
  a_tick_shared_rate: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    !tick_reg |=> tick_reg)
    else $error("tick gap longer than two cycles");

  a_grant_readback: assert property (@(posedge aclk) disable iff (!aresetn) // R5
    ar_take && rd_slot == SLOT_CFG |=> rdata_reg[GRANT_STATE_BIT] == $past(grant_n_reg))
    else $error("grant state bit mismatch");
  a_request_readback: assert property (@(posedge aclk) disable iff (!aresetn) // R6
    ar_take && rd_slot == SLOT_CFG |=> rdata_reg[REQUEST_STATE_BIT] == $past(req_sync_reg))
    else $error("request state bit mismatch");
  a_hold_blocks: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    cfg_reg.hold |=> grant_n_reg && !bus_release)
    else $error("grant given while hold set");

  a_auto_grant: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    !cfg_reg.hold |=> grant_n_reg == $past(req_sync_reg))
    else $error("grant does not follow request");

  a_hold_revokes: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    s_granted ##0 s_hold_write |-> ##2 grant_n_reg[*2])
    else $error("grant not revoked after hold write");

  a_hold_reset: assert property (@(posedge aclk) // R9
    !aresetn |=> !cfg_reg.hold && grant_n_reg)
    else $error("hold or grant wrong after reset");

endmodule : ext_bus_config_register

// [ext_bus_config_register_test.sv]
// Self-checking bench for the external interface configuration bank.
// Assumes an AXI4-Lite master here and a requester model on the pins.
`timescale 1ns/1ps
module ext_bus_config_register_test;
  import ext_cfg_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, want;
  logic awready, wready, bvalid, arready, rvalid, req_n, grant_n, rel, tick, irq, granted;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [33:0] exp_q[$];
  logic [2:0] ratio;
  int num_errors = 0, n_tests = 0, seed = 32'h3dcf, cnt, i;

  ext_bus_config_register i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bus_request_n(req_n), .bus_grant_n(grant_n), .bus_release(rel), .timing_tick(tick), .irq(irq));
  bus_requester i_req (.aclk(aclk), .want(want), .bus_grant_n(grant_n), .bus_request_n(req_n),
    .granted(granted));

  // ----------------------------------------------------------------
  // Clock, checks and closing
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] expv);
    n_tests++;
    if (seen !== expv) begin
      num_errors++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Whole run is under two hundred cycles; this margin of 5000 cycles only cuts a hang
  initial begin
    #(100 * 5000);
    num_errors++;
    test_done;
  end

  function automatic logic [31:0] cfgv(logic [2:0] r, logic h, logic g, logic q);
    return {13'h0, r, 4'h0, g, q, h, 9'h0};
  endfunction : cfgv

  // Monitor: every response is matched against the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready)
      check({rresp, rdata}, exp_q.pop_front());
    if (bvalid && bready)
      check({bresp, 32'h0}, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Response ready stays high between transfers, so back-to-back calls never
  // drive the same signal twice in one time step
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
  endtask : wr

  task rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
  endtask : rd

  task wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, want} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    aresetn = 1'b0;
    wait_cyc(4);
    aresetn <= 1'b1;
    wait_cyc(1);
    rd(CFG_OFFSET, cfgv(RATIO_RESET, HOLD_RESET, 1'b1, 1'b1), RESP_OKAY);
    rd(IRQ_MASK_OFFSET, 32'h0, RESP_OKAY);
    rd(32'hc, 32'h0, RESP_SLVERR);
    wr(32'h10, 32'hffff_ffff, 4'hf, RESP_SLVERR);
    wr(IRQ_STATUS_OFFSET, 32'h7, 4'hf, RESP_OKAY);
    $display("Reset values and unmapped access done");
    // Software only writes the two defined encodings
    for (i = 0; i < 4; i++) begin
      // Alternate the two encodings; random noise in the other bits must not stick
      ratio = 3'(i) & 3'h1;
      wr(CFG_OFFSET, (32'($random(seed)) & 32'hfff8_ffff) | {13'h0, ratio, 16'h0}, 4'h4, RESP_OKAY);
      wait_cyc(2);
      cnt = 0;
      repeat (8) begin
        @(posedge aclk);
        cnt += (tick === 1'b1);
      end
      check(cnt, (ratio == RATIO_DIV1) ? 8 : 4);
      rd(CFG_OFFSET, cfgv(ratio, 1'b0, 1'b1, 1'b1), RESP_OKAY);
    end
    $display("Timing ratio done");
    wr(IRQ_MASK_OFFSET, 32'h7, 4'h1, RESP_OKAY);
    want <= 1'b1;
    cnt = 0;
    while (grant_n !== 1'b0 && cnt < 20) begin
      @(posedge aclk);
      cnt++;
    end
    wait_cyc(1);
    check({grant_n, rel, granted, irq}, 4'b0111);
    rd(CFG_OFFSET, cfgv(ratio, 1'b0, 1'b0, 1'b0), RESP_OKAY);
    rd(IRQ_STATUS_OFFSET, 32'h3, RESP_OKAY);
    wait_cyc(2);
    check(irq, 1'b0);
    wr(CFG_OFFSET, 32'h200, 4'h2, RESP_OKAY);
    wait_cyc(2);
    check({grant_n, rel}, 2'b10);
    rd(IRQ_STATUS_OFFSET, 32'h4, RESP_OKAY);
    wait_cyc(6);
    check(grant_n, 1'b1);
    rd(CFG_OFFSET, cfgv(ratio, 1'b1, 1'b1, 1'b0), RESP_OKAY);
    $display("Grant and hold done");
    want <= 1'b0;
    wait_cyc(4);
    wr(CFG_OFFSET, 32'h0, 4'h2, RESP_OKAY);
    wait_cyc(6);
    check({grant_n, rel}, 2'b10);
    rd(CFG_OFFSET, cfgv(ratio, 1'b0, 1'b1, 1'b1), RESP_OKAY);
    $display("Release done");
    test_done;
  end
endmodule : ext_bus_config_register_test

// [ext_cfg_pkg.sv]
// Constants and types for the external interface configuration register bank.
// Assumes a single system clock and an AXI4-Lite master on the core side.
package ext_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] CFG_OFFSET = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;

  // ----------------------------------------------------------------
  // Field layout of external_interface_config
  // ----------------------------------------------------------------
  localparam int RATIO_LSB = 16;
  localparam int RATIO_MSB = 18;
  localparam int GRANT_STATE_BIT = 11;
  localparam int REQUEST_STATE_BIT = 10;
  localparam int HOLD_CTRL_BIT = 9;

  // Ratio encodings; all others are reserved
  localparam logic [2:0] RATIO_DIV1 = 3'h0;
  localparam logic [2:0] RATIO_DIV2 = 3'h1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RATIO_RESET = 3'h1;
  localparam logic HOLD_RESET = 1'b0;
  localparam int EVENT_COUNT = 3;
  localparam logic [EVENT_COUNT-1:0] MASK_RESET = 3'h0;

  // Interrupt event bit positions
  localparam int EV_REQUEST = 0;
  localparam int EV_GRANT = 1;
  localparam int EV_RELEASE = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SLOT_CFG,
    SLOT_STATUS,
    SLOT_MASK,
    SLOT_NONE
  } slot_e;

  typedef struct packed {
    logic [2:0] ratio;
    logic hold;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{ratio: RATIO_RESET, hold: HOLD_RESET};

endpackage : ext_cfg_pkg
